// ==== cscr_cpu_model.sv ====
// cpu core model: register writes, reads and STOP execution
`timescale 1ns/1ps
module cscr_cpu_model (
   input wire logic ref_clk, // cpu clock
   input wire logic [7:0] reg_rdata, // read data
   output logic reg_wr, // write strobe
   output logic [7:0] reg_addr, // address
   output logic [7:0] reg_wdata, // write data
   output logic stop_exec // STOP executes
);
   // ----
   // bus cycles
   // ----
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      stop_exec = 1'b0;
   end
   // one-cycle write, optionally with STOP in the same cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic s);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      stop_exec <= s;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      stop_exec <= 1'b0;
      reg_wdata <= ~d; // released data lines do not keep the value
   endtask
   task automatic stop();
      @(posedge ref_clk);
      stop_exec <= 1'b1;
      @(posedge ref_clk);
      stop_exec <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
endmodule // cscr_cpu_model

// ==== cscr_ctrl.sv ====
// module: stop key, clock select/divide and reset sequencing
`timescale 1ns/1ps
//--------------------------------------------------------------
// Operation
// [RULE_01] 8-bit stop key register, address EDh, resets 0
// [RULE_02] STOP allowed only when key equals 10100101
// [RULE_03] forbidden STOP gives system reset, no stop
// [RULE_04] after reset STOP is disabled
// [RULE_05] select bit 0 main, 1 sub oscillator
// [RULE_06] separate main and sub oscillator stop bits
// [RULE_07] two-bit divider gives 1, 2, 8, 16
// [RULE_08] software sets divider 11 on sub clock
// [RULE_09] software: divider 11, select sub, stop main
// [RULE_10] software: run main, wait, then select main
// [RULE_11] reset pin synchronised to cpu clock
// [RULE_12] reset pin held low one millisecond
// [RULE_13] reset pin low restores register defaults
// [RULE_14] reset disables interrupts, enables watchdog
// [RULE_15] reset sets ports input, pull-ups off
// [RULE_16] reset loads program counter with 0100h
// [RULE_17] fetch waits for stabilisation, then normal mode
// [RULE_18] reset address replaceable by boot option
// [RULE_19] divider 00 /16, 01 /8, 10 /2, 11 /1
// [RULE_20] stop bit 0 runs oscillator, 1 halts
// [RULE_21] key sampled when STOP executes
//--------------------------------------------------------------
module cscr_ctrl #(
   parameter int STAB_CYCLES = cscr_pkg::STAB_CYCLES_DEFAULT
) (
   input wire logic ref_clk, // cpu clock
   input wire logic reset_n, // block reset, sync active low
   input wire logic reset_pin_n, // asynchronous reset pin
   input wire logic reg_wr, // register write strobe
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   output logic [7:0] reg_rdata, // registered read data
   input wire logic stop_exec, // STOP instruction executes
   input wire logic boot_vec_en, // boot option replaces vector
   input wire logic [15:0] boot_vec, // boot option reset vector
   output logic sys_reset_q, // system reset to core
   output logic stop_mode_q, // stop mode entered
   output logic fetch_enable_q, // first fetch may start
   output logic [15:0] pc_load_q, // reset program counter value
   output logic int_disable_q, // all interrupts disabled
   output logic wdt_enable_q, // watchdog enabled
   output logic ports_input_q, // ports 0-4 forced to input
   output logic pullup_off_q, // all pull-ups off
   output logic osc_sel_sub_q, // 1 = sub clock is cpu clock
   output logic main_osc_run_q, // main oscillator runs
   output logic sub_osc_run_q, // sub oscillator runs
   output logic cpu_clk_en_q // cpu clock enable after divide
);
   //-----------------------------------------------------------
   // functions
   //-----------------------------------------------------------
   function automatic logic [3:0] div_limit(input logic [1:0] sel);
      case (sel)
         cscr_pkg::DIV_SEL_16: div_limit = cscr_pkg::DIV_CNT_16;
         cscr_pkg::DIV_SEL_8: div_limit = cscr_pkg::DIV_CNT_8;
         cscr_pkg::DIV_SEL_2: div_limit = cscr_pkg::DIV_CNT_2;
         default: div_limit = cscr_pkg::DIV_CNT_1;
      endcase
   endfunction

   //-----------------------------------------------------------
   // reset pin synchroniser
   //-----------------------------------------------------------
   logic pin_s1_q, pin_s2_q;
   always_ff @(posedge ref_clk) begin
      pin_s1_q <= reset_pin_n; // RULE_11
      pin_s2_q <= pin_s1_q;
   end

   //-----------------------------------------------------------
   // registers
   //-----------------------------------------------------------
   logic [7:0] key_q, key_d, osc_q, osc_d, div_q, div_d;
   logic [7:0] rdata_d;
   logic key_ok;
   logic any_rst;
   logic bad_stop_q, bad_stop_d;
   assign any_rst = !reset_n || !pin_s2_q || bad_stop_q;
   // key compared live, so a write in the same cycle as STOP counts
   assign key_ok = ((reg_wr && reg_addr == cscr_pkg::STOP_KEY_ADDR)
      ? reg_wdata : key_q) == cscr_pkg::STOP_KEY_ENABLE; // RULE_02 RULE_21

   always_comb begin
      key_d = key_q;
      osc_d = osc_q;
      div_d = div_q;
      if (reg_wr) begin
         case (reg_addr)
            cscr_pkg::STOP_KEY_ADDR: key_d = reg_wdata; // RULE_01
            cscr_pkg::OSC_CTRL_ADDR:
               osc_d = reg_wdata & cscr_pkg::OSC_CTRL_MASK; // RULE_06
            cscr_pkg::CLK_DIV_ADDR:
               div_d = reg_wdata & cscr_pkg::CLK_DIV_MASK;
            default: key_d = key_q;
         endcase
      end
      case (reg_addr)
         cscr_pkg::STOP_KEY_ADDR: rdata_d = key_q;
         cscr_pkg::OSC_CTRL_ADDR: rdata_d = osc_q;
         cscr_pkg::CLK_DIV_ADDR: rdata_d = div_q;
         default: rdata_d = 8'h00;
      endcase
      bad_stop_d = stop_exec && !key_ok && !any_rst; // RULE_03
   end

   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         key_q <= cscr_pkg::STOP_KEY_RESET; // RULE_04 RULE_13
         osc_q <= cscr_pkg::OSC_CTRL_RESET;
         div_q <= cscr_pkg::CLK_DIV_RESET; // RULE_19
         reg_rdata <= 8'h00;
      end else begin
         key_q <= key_d;
         osc_q <= osc_d;
         div_q <= div_d;
         reg_rdata <= rdata_d;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n) bad_stop_q <= 1'b0;
      else bad_stop_q <= bad_stop_d;
   end

   //-----------------------------------------------------------
   // oscillator select and divider
   //-----------------------------------------------------------
   logic [1:0] div_sel;
   logic [3:0] div_cnt_q, div_cnt_d;
   logic clk_en_d;
   assign div_sel = div_q[cscr_pkg::DIV_HI_BIT:cscr_pkg::DIV_LO_BIT];
   always_comb begin
      clk_en_d = (div_cnt_q >= div_limit(div_sel)); // RULE_07 RULE_19
      div_cnt_d = clk_en_d ? 4'h0 : div_cnt_q + 4'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         div_cnt_q <= 4'h0;
         cpu_clk_en_q <= 1'b0;
         osc_sel_sub_q <= 1'b0;
         main_osc_run_q <= 1'b1;
         sub_osc_run_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_d;
         cpu_clk_en_q <= clk_en_d && !stop_mode_q;
         osc_sel_sub_q <= osc_q[cscr_pkg::OSC_SEL_BIT]; // RULE_05
         main_osc_run_q <= !osc_q[cscr_pkg::MAIN_STOP_BIT]
            && !stop_mode_q; // RULE_20
         sub_osc_run_q <= !osc_q[cscr_pkg::SUB_STOP_BIT]; // RULE_20
      end
   end

   //-----------------------------------------------------------
   // reset sequence
   //-----------------------------------------------------------
   cscr_pkg::cscr_rst_e st_q, st_d;
   logic [15:0] stab_q, stab_d;
   logic stop_d;
   always_comb begin
      st_d = st_q;
      stab_d = stab_q;
      stop_d = stop_mode_q;
      case (st_q)
         cscr_pkg::CSCR_RST_HOLD: begin
            st_d = cscr_pkg::CSCR_RST_WAIT;
            stab_d = 16'h0000;
         end
         cscr_pkg::CSCR_RST_WAIT: begin
            stab_d = stab_q + 16'h0001;
            if (stab_q >= 16'(STAB_CYCLES - 1))
               st_d = cscr_pkg::CSCR_RST_RUN; // RULE_17
         end
         cscr_pkg::CSCR_RST_RUN: begin
            if (stop_exec && key_ok) stop_d = 1'b1; // RULE_02
         end
         default: st_d = cscr_pkg::CSCR_RST_HOLD;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (any_rst) begin
         st_q <= cscr_pkg::CSCR_RST_HOLD;
         stab_q <= 16'h0000;
         stop_mode_q <= 1'b0;
         sys_reset_q <= 1'b1;
         fetch_enable_q <= 1'b0;
         int_disable_q <= 1'b1; // RULE_14
         wdt_enable_q <= 1'b1; // RULE_14
         ports_input_q <= 1'b1; // RULE_15
         pullup_off_q <= 1'b1; // RULE_15
         pc_load_q <= cscr_pkg::RESET_VECTOR; // RULE_16
      end else begin
         st_q <= st_d;
         stab_q <= stab_d;
         stop_mode_q <= stop_d;
         sys_reset_q <= 1'b0;
         fetch_enable_q <= (st_d == cscr_pkg::CSCR_RST_RUN);
         int_disable_q <= int_disable_q;
         wdt_enable_q <= wdt_enable_q;
         ports_input_q <= ports_input_q;
         pullup_off_q <= pullup_off_q;
         if (st_q == cscr_pkg::CSCR_RST_HOLD)
            pc_load_q <= boot_vec_en ? boot_vec
               : cscr_pkg::RESET_VECTOR; // RULE_18
      end
   end

   //-----------------------------------------------------------
   // checks
   //-----------------------------------------------------------
   AST_KEY_RESET: assert property (@(posedge ref_clk) // RULE_04
      !reset_n |=> key_q == cscr_pkg::STOP_KEY_RESET)
      else $error("key not cleared by reset");
   AST_KEY_WRITE: assert property (@(posedge ref_clk) // RULE_01
      disable iff (!reset_n)
      (reg_wr && reg_addr == cscr_pkg::STOP_KEY_ADDR && !any_rst)
      |=> key_q == $past(reg_wdata))
      else $error("key write lost");
   AST_BAD_STOP: assert property (@(posedge ref_clk) // RULE_03
      disable iff (!reset_n)
      (stop_exec && !key_ok && !any_rst) |=> ##1 sys_reset_q && !stop_mode_q)
      else $error("forbidden stop did not reset");
   AST_GOOD_STOP: assert property (@(posedge ref_clk) // RULE_02
      disable iff (!reset_n)
      (st_q == cscr_pkg::CSCR_RST_RUN && stop_exec && key_ok && !any_rst)
      |=> stop_mode_q)
      else $error("permitted stop not entered");
   AST_PIN_SYNC: assert property (@(posedge ref_clk) // RULE_11
      disable iff (!reset_n)
      !reset_pin_n |-> ##3 sys_reset_q)
      else $error("reset pin not honoured");
   // a reset cycle clears osc_q and the outputs together, so skip it
   AST_SEL: assert property (@(posedge ref_clk) // RULE_05
      disable iff (any_rst)
      !$past(any_rst) |-> osc_sel_sub_q == $past(osc_q[cscr_pkg::OSC_SEL_BIT]))
      else $error("clock select wrong");
   AST_DIV1: assert property (@(posedge ref_clk) // RULE_19
      disable iff (any_rst)
      (div_sel == cscr_pkg::DIV_SEL_1 && !stop_mode_q)[*2] |=> cpu_clk_en_q)
      else $error("divide by one not continuous");
   AST_FETCH: assert property (@(posedge ref_clk) // RULE_17
      disable iff (any_rst)
      (st_q == cscr_pkg::CSCR_RST_WAIT) |-> !fetch_enable_q)
      else $error("fetch before stabilisation");
   AST_MAIN_RUN: assert property (@(posedge ref_clk) // RULE_20
      disable iff (any_rst)
      !$past(any_rst) |-> main_osc_run_q == (!$past(osc_q[cscr_pkg::MAIN_STOP_BIT])
      && !$past(stop_mode_q)))
      else $error("main oscillator run wrong");
   AST_SUB_RUN: assert property (@(posedge ref_clk) // RULE_20
      disable iff (any_rst)
      !$past(any_rst) |-> sub_osc_run_q == !$past(osc_q[cscr_pkg::SUB_STOP_BIT]))
      else $error("sub oscillator run wrong");
   AST_OSC_WRITE: assert property (@(posedge ref_clk) // RULE_06
      disable iff (!reset_n)
      (reg_wr && reg_addr == cscr_pkg::OSC_CTRL_ADDR && !any_rst)
      |=> osc_q == ($past(reg_wdata) & cscr_pkg::OSC_CTRL_MASK))
      else $error("oscillator control write lost");
   AST_DIV_WRITE: assert property (@(posedge ref_clk) // RULE_07
      disable iff (!reset_n)
      (reg_wr && reg_addr == cscr_pkg::CLK_DIV_ADDR && !any_rst)
      |=> div_q == ($past(reg_wdata) & cscr_pkg::CLK_DIV_MASK))
      else $error("divider write lost");
   AST_DIV_RESET: assert property (@(posedge ref_clk) // RULE_19
      !reset_n |=> div_q == cscr_pkg::CLK_DIV_RESET)
      else $error("divider not slowest after reset");
   AST_PORTS_RESET: assert property (@(posedge ref_clk) // RULE_15
      !reset_n |=> ports_input_q && pullup_off_q)
      else $error("ports not input after reset");
   AST_BOOT_VEC: assert property (@(posedge ref_clk) // RULE_18
      disable iff (any_rst)
      (st_q == cscr_pkg::CSCR_RST_HOLD && boot_vec_en)
      |=> pc_load_q == $past(boot_vec))
      else $error("boot vector not loaded");
   AST_NO_STOP_RST: assert property (@(posedge ref_clk) // RULE_04
      any_rst |=> !stop_mode_q)
      else $error("stop mode survives reset");
   AST_RST_ASSERT: assert property (@(posedge ref_clk) // RULE_13
      any_rst |=> sys_reset_q && !fetch_enable_q)
      else $error("system reset not driven");
   AST_STOP_CLK: assert property (@(posedge ref_clk) // RULE_02
      disable iff (any_rst)
      stop_mode_q |=> !cpu_clk_en_q)
      else $error("cpu clock runs in stop mode");
   AST_STOP_HOLDS: assert property (@(posedge ref_clk) // RULE_02
      disable iff (any_rst)
      stop_mode_q |=> stop_mode_q)
      else $error("stop mode left without reset");
   AST_RDATA: assert property (@(posedge ref_clk) // RULE_01
      disable iff (any_rst)
      (reg_addr == cscr_pkg::STOP_KEY_ADDR) |=> reg_rdata == $past(key_q))
      else $error("key read data wrong");
   AST_HOLD_WAIT: assert property (@(posedge ref_clk) // RULE_17
      disable iff (any_rst)
      (st_q == cscr_pkg::CSCR_RST_HOLD) |=> st_q == cscr_pkg::CSCR_RST_WAIT)
      else $error("stabilisation wait not started");
   AST_KEY_LIVE: assert property (@(posedge ref_clk) // RULE_21
      disable iff (any_rst)
      (st_q == cscr_pkg::CSCR_RST_RUN && stop_exec && reg_wr
      && reg_addr == cscr_pkg::STOP_KEY_ADDR
      && reg_wdata == cscr_pkg::STOP_KEY_ENABLE)
      |=> stop_mode_q && !bad_stop_q)
      else $error("key written with stop not honoured");
   AST_RST_OUT: assert property (@(posedge ref_clk) // RULE_14
      !reset_n |=> int_disable_q && wdt_enable_q && ports_input_q
      && pc_load_q == cscr_pkg::RESET_VECTOR)
      else $error("reset outputs wrong");
endmodule : cscr_ctrl

// ==== cscr_pkg.sv ====
// package: constants for the clock, stop and reset control block
package cscr_pkg;
   localparam logic [7:0] STOP_KEY_ADDR = 8'hed;
   localparam logic [7:0] OSC_CTRL_ADDR = 8'hfa;
   localparam logic [7:0] CLK_DIV_ADDR = 8'hd4;
   localparam logic [7:0] STOP_KEY_RESET = 8'h00;
   localparam logic [7:0] STOP_KEY_ENABLE = 8'ha5;
   localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
   localparam logic [7:0] CLK_DIV_RESET = 8'h00;
   localparam int OSC_SEL_BIT = 0;
   localparam int SUB_STOP_BIT = 2;
   localparam int MAIN_STOP_BIT = 3;
   localparam int DIV_LO_BIT = 3;
   localparam int DIV_HI_BIT = 4;
   localparam logic [7:0] OSC_CTRL_MASK = 8'h0d;
   localparam logic [7:0] CLK_DIV_MASK = 8'h98;
   localparam logic [1:0] DIV_SEL_16 = 2'h0;
   localparam logic [1:0] DIV_SEL_8 = 2'h1;
   localparam logic [1:0] DIV_SEL_2 = 2'h2;
   localparam logic [1:0] DIV_SEL_1 = 2'h3;
   localparam logic [3:0] DIV_CNT_16 = 4'hf;
   localparam logic [3:0] DIV_CNT_8 = 4'h7;
   localparam logic [3:0] DIV_CNT_2 = 4'h1;
   localparam logic [3:0] DIV_CNT_1 = 4'h0;
   localparam logic [15:0] RESET_VECTOR = 16'h0100;
   localparam int STAB_CYCLES_DEFAULT = 256;
   typedef enum logic [2:0] {
      CSCR_RST_HOLD = 3'b001,
      CSCR_RST_WAIT = 3'b010,
      CSCR_RST_RUN = 3'b100
   } cscr_rst_e;
endpackage : cscr_pkg

// ==== tb_top.sv ====
// testbench: clock, stop and reset control scenarios
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reset_pin_n = 1'b1;
   logic boot_vec_en = 1'b0;
   logic [15:0] boot_vec = 16'h2000;
   logic reg_wr, stop_exec, sys_reset_q, stop_mode_q, fetch_enable_q;
   logic int_disable_q, wdt_enable_q, ports_input_q, pullup_off_q;
   logic osc_sel_sub_q, main_osc_run_q, sub_osc_run_q, cpu_clk_en_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
   logic [15:0] pc_load_q;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   localparam int PIN_LOW_CYCLES = 20000; // 1 ms at 50 ns
   localparam int MAX_CYCLES = 25000;
   cscr_ctrl #(.STAB_CYCLES(4)) u_dut (.ref_clk, .reset_n, .reset_pin_n,
      .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .stop_exec,
      .boot_vec_en, .boot_vec, .sys_reset_q, .stop_mode_q,
      .fetch_enable_q, .pc_load_q, .int_disable_q, .wdt_enable_q,
      .ports_input_q, .pullup_off_q, .osc_sel_sub_q, .main_osc_run_q,
      .sub_osc_run_q, .cpu_clk_en_q);
   cscr_cpu_model u_cpu (.ref_clk, .reg_rdata, .reg_wr, .reg_addr,
      .reg_wdata, .stop_exec);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == MAX_CYCLES) begin
         errors++;
         report_and_stop();
      end
   end
   // ----
   // helpers and scenarios
   // ----
   task automatic report_and_stop();
      $display("errors=%0d n_compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      u_cpu.rd(a, rd_v);
      chk(rd_v, e);
   endtask
   task automatic wait_run();
      for (int i = 0; i < 20 && fetch_enable_q !== 1'b1; i++) cyc(1);
      chk({fetch_enable_q, sys_reset_q}, 2'h2);
   endtask
   task automatic t_reset();
      cyc(2);
      chk(fetch_enable_q, 1'b0);
      chk(pc_load_q, 16'h0100);
      chk({int_disable_q, wdt_enable_q}, 2'h3);
      chk({ports_input_q, pullup_off_q}, 2'h3);
      chk({osc_sel_sub_q, main_osc_run_q, sub_osc_run_q}, 3'h3);
      wait_run();
      rdc(8'hed, 8'h00);
      rdc(8'hd4, 8'h00);
   endtask
   task automatic t_div();
      int n;
      int per [4] = '{16, 8, 2, 1};
      for (int k = 0; k < 4; k++) begin
         u_cpu.wr(8'hd4, {3'h0, 2'(k), 3'h0}, 1'b0);
         cyc(20);
         for (n = 0; n < 40 && cpu_clk_en_q !== 1'b1; n++) cyc(1);
         for (n = 1; n < 40; n++) begin
            cyc(1);
            if (cpu_clk_en_q === 1'b1) break;
         end
         chk(16'(n), 16'(per[k]));
      end
   endtask
   task automatic t_osc();
      u_cpu.wr(8'hd4, 8'h18, 1'b0);
      u_cpu.wr(8'hfa, 8'h01, 1'b0);
      u_cpu.wr(8'hfa, 8'h09, 1'b0);
      cyc(3);
      chk({osc_sel_sub_q, main_osc_run_q, sub_osc_run_q}, 3'h5);
      u_cpu.wr(8'hfa, 8'h01, 1'b0);
      cyc(8);
      chk({osc_sel_sub_q, main_osc_run_q, sub_osc_run_q}, 3'h7);
      u_cpu.wr(8'hfa, 8'h00, 1'b0);
      cyc(3);
      chk({osc_sel_sub_q, main_osc_run_q, sub_osc_run_q}, 3'h3);
   endtask
   task automatic t_regs();
      u_cpu.wr(8'hfa, 8'hf6, 1'b0);
      cyc(3);
      chk({main_osc_run_q, sub_osc_run_q}, 2'h2);
      rdc(8'hfa, 8'h04);
      u_cpu.wr(8'hd4, 8'hff, 1'b0);
      rdc(8'hd4, 8'h98);
      u_cpu.wr(8'h10, 8'hff, 1'b0);
      rdc(8'h10, 8'h00);
      u_cpu.wr(8'hed, 8'h5a, 1'b0);
      rdc(8'hed, 8'h5a);
   endtask
   task automatic t_stop();
      u_cpu.stop();
      cyc(1);
      chk({sys_reset_q, stop_mode_q}, 2'h2);
      wait_run();
      rdc(8'hed, 8'h00);
      rdc(8'hfa, 8'h00);
      u_cpu.wr(8'hed, 8'ha5, 1'b1);
      cyc(2);
      chk({sys_reset_q, stop_mode_q, main_osc_run_q}, 3'h2);
      @(posedge ref_clk);
      reset_pin_n <= 1'b0;
      boot_vec_en <= 1'b1;
      cyc(1);
      chk(sys_reset_q, 1'b0);
      cyc(4);
      chk(sys_reset_q, 1'b1);
      cyc(PIN_LOW_CYCLES);
      @(posedge ref_clk);
      reset_pin_n <= 1'b1;
      wait_run();
      chk({stop_mode_q, pc_load_q}, 17'h0_2000);
      rdc(8'hed, 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_div();
      t_osc();
      t_regs();
      t_stop();
      report_and_stop();
   end
endmodule // tb_top
